// ---- common/watchdog_reset_flag_pkg.sv ----
// Shared constants and types of the watchdog, reset flag and supply monitor block
package watchdog_reset_flag_pkg;
   // Register indices; the byte address on the bus is four times the index
   localparam logic [5:0] IDX_WDT = 6'h31;
   localparam logic [5:0] IDX_RSF = 6'h3b;
   localparam logic [5:0] IDX_SUP = 6'h34;
   localparam logic [5:0] IDX_UNLOCK = 6'h3c;
   localparam int ADR_W = 8;
   localparam int DAT_W = 32;
   localparam int SEL_W = 4;

   // Watchdog control and status fields
   localparam logic [7:0] WDT_RESET = 8'h00;
   localparam int B_TO_FLAG = 7;
   localparam int B_TO_EN = 6;
   localparam int B_PSEL3 = 5;
   localparam int B_RST_EN = 3;

   // Reset source flag fields
   localparam int B_WD_RST = 3;
   localparam int B_PIN_RST = 1;
   localparam int B_PWR_ON = 0;

   // Supply monitor fields
   localparam int B_LOW_FLAG = 7;
   localparam int B_LOW_EN = 6;

   // Protected change
   localparam logic [7:0] UNLOCK_SIG = 8'hd8;
   localparam int PROT_WINDOW = 4;

   // Watchdog oscillator and time-out range
   localparam int WDOSC_KHZ = 128;
   localparam int CNT_W = 20;
   localparam int BASE_CYCLES = 2048;
   localparam logic [3:0] PSEL_MAX = 4'h9;

   // Synchroniser bit positions
   localparam int S_OSC = 0;
   localparam int S_FUSE = 1;
   localparam int S_PIN = 2;
   localparam int S_LOW = 3;
   localparam int SYNC_W = 4;

   typedef enum logic [1:0] {
      WATCHDOG_RESET_FLAG_STOPPED = 2'h0,
      WATCHDOG_RESET_FLAG_IRQ = 2'h1,
      WATCHDOG_RESET_FLAG_RST = 2'h2,
      WATCHDOG_RESET_FLAG_IRQ_RST = 2'h3
   } watchdog_reset_flag_mode_t;

   typedef enum logic [2:0] {
      WATCHDOG_RESET_FLAG_LVL_OFF = 3'h0,
      WATCHDOG_RESET_FLAG_LVL_POR_L = 3'h1,
      WATCHDOG_RESET_FLAG_LVL_POR_H = 3'h2,
      WATCHDOG_RESET_FLAG_LVL_FLAG_A = 3'h3,
      WATCHDOG_RESET_FLAG_LVL_FLAG_B = 3'h4
   } watchdog_reset_flag_lvl_t;
endpackage

// ---- common/watchdog_reset_flag_cnt_if.sv ----
// Link between the register logic and the watchdog counter
interface watchdog_reset_flag_cnt_if;
   logic tick;
   logic restart;
   logic [3:0] psel;
   logic timeout;
   modport ctl (output tick, output restart, output psel, input timeout);
   modport cnt (input tick, input restart, input psel, output timeout);
endinterface

// ---- verilog/watchdog_reset_flag_sync.sv ----
// Two flip-flop synchroniser for pin inputs
module watchdog_reset_flag_sync #(
   parameter int W = watchdog_reset_flag_pkg::SYNC_W
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] s1;

   // First stage feeds only the second stage
   always_ff @(posedge mclk) begin
      if (rst) begin
         s1 <= '0;
         q <= '0;
      end else begin
         s1 <= d;
         q <= s1;
      end
   end
endmodule

// ---- verilog/watchdog_reset_flag_wd_counter.sv ----
// Watchdog time-out counter driven by oscillator ticks
module watchdog_reset_flag_wd_counter #(
   parameter int CNT_W = watchdog_reset_flag_pkg::CNT_W
) (
   input wire logic mclk,
   input wire logic rst,
   watchdog_reset_flag_cnt_if.cnt bus
);
   logic [CNT_W-1:0] cnt;
   logic [3:0] sel;
   logic [CNT_W-1:0] limit;

   // Reserved codes are clamped to the longest period
   assign sel = (bus.psel > watchdog_reset_flag_pkg::PSEL_MAX) ? watchdog_reset_flag_pkg::PSEL_MAX : bus.psel;
   assign limit = CNT_W'((watchdog_reset_flag_pkg::BASE_CYCLES << sel) - 1); // see RULE11

   always_ff @(posedge mclk) begin
      if (rst || bus.restart) begin // see RULE15
         cnt <= '0;
         bus.timeout <= 1'b0;
      end else begin
         bus.timeout <= 1'b0;
         if (bus.tick) begin // see RULE14
            if (cnt == limit) begin
               cnt <= '0;
               bus.timeout <= 1'b1;
            end else begin
               cnt <= cnt + 1'b1;
            end
         end
      end
   end

   property p_cnt_limit;
      @(posedge mclk) disable iff (rst) bus.timeout |-> $past(cnt) == $past(limit);
   endproperty
   a_cnt_limit: assert property (p_cnt_limit) else $error("time-out off limit"); // see RULE11

   property p_cnt_restart;
      @(posedge mclk) disable iff (rst) bus.restart |=> cnt == '0 && !bus.timeout;
   endproperty
   a_cnt_restart: assert property (p_cnt_restart) else $error("restart ignored"); // see RULE15
endmodule

// ---- verilog/watchdog_reset_flag_top.sv ----
// Watchdog, reset source flags and supply monitor with a Wishbone register port

// What this block does
// RULE1: Time-out in interrupt operation sets the watchdog interrupt flag, bit 7.
// RULE2: Taking the watchdog interrupt vector clears the flag in hardware.
// RULE3: Writing one to the flag clears it; writing zero leaves it.
// RULE4: Interrupt request only with global enable, watchdog enable and flag all set.
// RULE5: Unfused decode: stopped, interrupt, reset, or interrupt then reset.
// RULE6: Fuse programmed forces reset mode regardless of control bits.
// RULE7: Combined mode: first time-out sets flag; vector clears enable and flag.
// RULE8: Combined mode: unserviced flag at next time-out gives a system reset.
// RULE9: Software re-arms the interrupt enable after each interrupt, outside the handler.
// RULE10: Reset enable reads and acts as one while the watchdog reset flag is set.
// RULE11: Prescaler bits 5 and 2:0 select 2048 up to 1048576 oscillator cycles.
// RULE12: Software never writes prescaler codes 1010 to 1111.
// RULE13: Disabling needs restart, flag clear, signature 0xD8, then write within four cycles.
// RULE14: The counter runs from the separate 128 kHz watchdog oscillator.
// RULE15: Counter restarts on restart command, while disabled, and on any reset.
// RULE16: A watchdog reset is a pulse of exactly one system clock.
// RULE17: Supply flag sets on trigger; clears when disabled or supply recovers.
// RULE18: With its enable set, each setting of the supply flag requests an interrupt.
// RULE19: Level 000 off, 001/010 power-on reset, 011/100 flag and interrupt.
// RULE20: Watchdog reset flag, bit 3, set by watchdog reset, cleared by POR or zero.
// RULE21: Pin reset flag, bit 1, set by pin reset, cleared by POR or zero.
// RULE22: Power-on flag, bit 0, set by power-on reset, cleared only by zero.
// RULE23: Software reads then clears the reset flags early after start-up.
module watchdog_reset_flag_top #(
   parameter int PROT_WIN = watchdog_reset_flag_pkg::PROT_WINDOW
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic wb_cyc,
   input wire logic wb_stb,
   input wire logic wb_we,
   input wire logic [watchdog_reset_flag_pkg::ADR_W-1:0] wb_adr,
   input wire logic [watchdog_reset_flag_pkg::SEL_W-1:0] wb_sel,
   input wire logic [watchdog_reset_flag_pkg::DAT_W-1:0] wb_dat_i,
   output logic [watchdog_reset_flag_pkg::DAT_W-1:0] wb_dat_o,
   output logic wb_ack,
   input wire logic wd_osc_clk,
   input wire logic wd_always_on_fuse,
   input wire logic wd_restart,
   input wire logic wd_vector_taken,
   input wire logic global_irq_enable,
   input wire logic pin_reset_req,
   input wire logic supply_below_level,
   output logic wd_irq_req,
   output logic wd_sys_reset,
   output logic supply_low_irq_req,
   output logic supply_por_req
);
   logic [watchdog_reset_flag_pkg::SYNC_W-1:0] pins_raw;
   logic [watchdog_reset_flag_pkg::SYNC_W-1:0] pins;
   logic osc_d;
   logic pin_d;
   logic pin_rise;
   logic fuse_prog;
   logic below;

   logic wd_timeout_irq_flag;
   logic wd_timeout_irq_enable;
   logic wd_system_reset_enable;
   logic [3:0] wd_prescale_select;
   logic rst_en_eff;
   logic watchdog_reset_flag;
   logic pin_reset_flag;
   logic power_on_reset_flag;
   logic supply_low_flag;
   logic supply_low_irq_enable;
   logic [2:0] supply_trigger_level;
   logic next_supply_low_flag;
   logic [2:0] win_cnt;
   logic win_open;

   logic req;
   logic [5:0] idx;
   logic wr;
   logic [7:0] wd;
   logic wr_wdt;
   logic wr_rsf;
   logic wr_sup;
   logic wr_unlock;
   logic [7:0] rd_byte;
   logic dev_reset;
   logic to_irq;
   logic to_rst;
   logic irq_cond;
   watchdog_reset_flag_pkg::watchdog_reset_flag_mode_t mode;

   watchdog_reset_flag_cnt_if cnt_bus ();

   assign pins_raw = {supply_below_level, pin_reset_req, wd_always_on_fuse, wd_osc_clk};

   watchdog_reset_flag_sync #(
      .W(watchdog_reset_flag_pkg::SYNC_W)
   ) u_sync (
      .mclk(mclk),
      .rst(rst),
      .d(pins_raw),
      .q(pins)
   );

   watchdog_reset_flag_wd_counter #(
      .CNT_W(watchdog_reset_flag_pkg::CNT_W)
   ) u_cnt (
      .mclk(mclk),
      .rst(rst),
      .bus(cnt_bus)
   );

   // Edge detectors read only the second synchroniser stage
   always_ff @(posedge mclk) begin
      if (rst) begin
         osc_d <= 1'b0;
         pin_d <= 1'b0;
      end else begin
         osc_d <= pins[watchdog_reset_flag_pkg::S_OSC];
         pin_d <= pins[watchdog_reset_flag_pkg::S_PIN];
      end
   end

   assign pin_rise = pins[watchdog_reset_flag_pkg::S_PIN] & ~pin_d;
   assign fuse_prog = ~pins[watchdog_reset_flag_pkg::S_FUSE];
   assign below = pins[watchdog_reset_flag_pkg::S_LOW];
   assign dev_reset = wd_sys_reset | pin_rise;

   // Bus decode; writes take effect on the edge that sees ack high
   assign req = wb_cyc & wb_stb;
   assign idx = wb_adr[watchdog_reset_flag_pkg::ADR_W-1:2];
   assign wd = wb_dat_i[7:0];
   assign wr = req & wb_we & wb_ack & wb_sel[0] & (wb_adr[1:0] == 2'h0);
   assign wr_wdt = wr & (idx == watchdog_reset_flag_pkg::IDX_WDT);
   assign wr_rsf = wr & (idx == watchdog_reset_flag_pkg::IDX_RSF);
   assign wr_sup = wr & (idx == watchdog_reset_flag_pkg::IDX_SUP);
   assign wr_unlock = wr & (idx == watchdog_reset_flag_pkg::IDX_UNLOCK);
   assign win_open = win_cnt != 3'h0;

   assign rst_en_eff = wd_system_reset_enable | watchdog_reset_flag | fuse_prog; // see RULE10

   always_comb begin
      rd_byte = 8'h00;
      if (wb_adr[1:0] == 2'h0) begin
         case (idx)
            watchdog_reset_flag_pkg::IDX_WDT: begin
               rd_byte = {wd_timeout_irq_flag, wd_timeout_irq_enable,
                          wd_prescale_select[3], 1'b0, rst_en_eff, wd_prescale_select[2:0]};
            end
            watchdog_reset_flag_pkg::IDX_RSF: begin
               rd_byte = {4'h0, watchdog_reset_flag, 1'b0, pin_reset_flag,
                          power_on_reset_flag};
            end
            watchdog_reset_flag_pkg::IDX_SUP: begin
               rd_byte = {supply_low_flag, supply_low_irq_enable, 3'h0,
                          supply_trigger_level};
            end
            default: begin
               rd_byte = 8'h00;
            end
         endcase
      end
   end

   // Unmapped addresses still ack and read zero so the master never hangs
   always_ff @(posedge mclk) begin
      if (rst) begin
         wb_ack <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack <= req & ~wb_ack;
         if (req && !wb_ack) begin
            wb_dat_o <= {24'h00_0000, rd_byte};
         end
      end
   end

   // Protected change window opened by the signature
   always_ff @(posedge mclk) begin
      if (rst) begin
         win_cnt <= 3'h0;
      end else if (wr_unlock && wd == watchdog_reset_flag_pkg::UNLOCK_SIG) begin // see RULE13
         win_cnt <= 3'(PROT_WIN);
      end else if (wr_wdt) begin
         win_cnt <= 3'h0;
      end else if (win_open) begin
         win_cnt <= win_cnt - 3'h1;
      end
   end

   // Operating mode
   always_comb begin
      if (fuse_prog) begin
         mode = watchdog_reset_flag_pkg::WATCHDOG_RESET_FLAG_RST; // see RULE6
      end else begin
         mode = watchdog_reset_flag_pkg::watchdog_reset_flag_mode_t'({rst_en_eff, wd_timeout_irq_enable}); // see RULE5
      end
   end

   always_comb begin
      to_irq = 1'b0;
      to_rst = 1'b0;
      case (mode)
         watchdog_reset_flag_pkg::WATCHDOG_RESET_FLAG_IRQ: begin
            to_irq = cnt_bus.timeout; // see RULE1
         end
         watchdog_reset_flag_pkg::WATCHDOG_RESET_FLAG_RST: begin
            to_rst = cnt_bus.timeout;
         end
         watchdog_reset_flag_pkg::WATCHDOG_RESET_FLAG_IRQ_RST: begin
            // A still pending flag means the handler never ran
            to_rst = cnt_bus.timeout & wd_timeout_irq_flag; // see RULE8
            to_irq = cnt_bus.timeout & ~wd_timeout_irq_flag; // see RULE7
         end
         default: begin
            to_irq = 1'b0;
            to_rst = 1'b0;
         end
      endcase
   end

   assign cnt_bus.tick = pins[watchdog_reset_flag_pkg::S_OSC] & ~osc_d; // see RULE14
   assign cnt_bus.restart = wd_restart | (mode == watchdog_reset_flag_pkg::WATCHDOG_RESET_FLAG_STOPPED) | dev_reset; // see RULE15
   assign cnt_bus.psel = wd_prescale_select; // see RULE11

   // Watchdog control register; a device reset returns it to its reset value
   always_ff @(posedge mclk) begin
      if (rst || dev_reset) begin
         wd_timeout_irq_flag <= watchdog_reset_flag_pkg::WDT_RESET[watchdog_reset_flag_pkg::B_TO_FLAG];
         wd_timeout_irq_enable <= watchdog_reset_flag_pkg::WDT_RESET[watchdog_reset_flag_pkg::B_TO_EN];
         wd_system_reset_enable <= watchdog_reset_flag_pkg::WDT_RESET[watchdog_reset_flag_pkg::B_RST_EN];
         wd_prescale_select <= {watchdog_reset_flag_pkg::WDT_RESET[watchdog_reset_flag_pkg::B_PSEL3],
                                watchdog_reset_flag_pkg::WDT_RESET[2:0]};
      end else begin
         // Set wins over both clears
         if (to_irq) begin
            wd_timeout_irq_flag <= 1'b1; // see RULE1
         end else if (wd_vector_taken) begin
            wd_timeout_irq_flag <= 1'b0; // see RULE2
         end else if (wr_wdt && wd[watchdog_reset_flag_pkg::B_TO_FLAG]) begin
            wd_timeout_irq_flag <= 1'b0; // see RULE3
         end
         if (wd_vector_taken && mode == watchdog_reset_flag_pkg::WATCHDOG_RESET_FLAG_IRQ_RST) begin
            wd_timeout_irq_enable <= 1'b0; // see RULE7
         end else if (wr_wdt) begin
            wd_timeout_irq_enable <= wd[watchdog_reset_flag_pkg::B_TO_EN];
         end
         if (watchdog_reset_flag) begin
            wd_system_reset_enable <= 1'b1; // see RULE10
         end else if (wr_wdt && (wd[watchdog_reset_flag_pkg::B_RST_EN] || win_open)) begin
            wd_system_reset_enable <= wd[watchdog_reset_flag_pkg::B_RST_EN]; // see RULE13
         end
         // Fused parts change the period only inside the window
         if (wr_wdt && (win_open || !fuse_prog)) begin
            wd_prescale_select <= {wd[watchdog_reset_flag_pkg::B_PSEL3], wd[2:0]};
         end
      end
   end

   // Outgoing requests
   assign irq_cond = global_irq_enable & wd_timeout_irq_enable & wd_timeout_irq_flag;

   always_ff @(posedge mclk) begin
      if (rst) begin
         wd_irq_req <= 1'b0;
         wd_sys_reset <= 1'b0;
      end else begin
         wd_irq_req <= irq_cond; // see RULE4
         wd_sys_reset <= to_rst & ~wd_sys_reset; // see RULE16
      end
   end

   // Reset source flags; the block reset stands for the power-on reset
   always_ff @(posedge mclk) begin
      if (rst) begin
         power_on_reset_flag <= 1'b1; // see RULE22
         watchdog_reset_flag <= 1'b0; // see RULE20
         pin_reset_flag <= 1'b0; // see RULE21
      end else begin
         watchdog_reset_flag <= wd_sys_reset |
            (watchdog_reset_flag & ~(wr_rsf & ~wd[watchdog_reset_flag_pkg::B_WD_RST])); // see RULE20
         pin_reset_flag <= pin_rise |
            (pin_reset_flag & ~(wr_rsf & ~wd[watchdog_reset_flag_pkg::B_PIN_RST])); // see RULE21
         power_on_reset_flag <= power_on_reset_flag &
            ~(wr_rsf & ~wd[watchdog_reset_flag_pkg::B_PWR_ON]); // see RULE22
      end
   end

   // Supply monitor
   always_comb begin
      next_supply_low_flag = supply_low_flag;
      if (supply_trigger_level == watchdog_reset_flag_pkg::WATCHDOG_RESET_FLAG_LVL_FLAG_A ||
          supply_trigger_level == watchdog_reset_flag_pkg::WATCHDOG_RESET_FLAG_LVL_FLAG_B) begin
         if (below) begin
            next_supply_low_flag = 1'b1; // see RULE19
         end else begin
            next_supply_low_flag = 1'b0; // see RULE17
         end
      end else begin
         next_supply_low_flag = 1'b0; // see RULE17
      end
      if (wr_sup && !below) begin
         if (!wd[watchdog_reset_flag_pkg::B_LOW_FLAG] || wd[2:0] != supply_trigger_level) begin
            next_supply_low_flag = 1'b0;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         supply_low_flag <= 1'b0;
         supply_low_irq_enable <= 1'b0;
         supply_trigger_level <= watchdog_reset_flag_pkg::WATCHDOG_RESET_FLAG_LVL_OFF;
         supply_low_irq_req <= 1'b0;
         supply_por_req <= 1'b0;
      end else begin
         supply_low_flag <= next_supply_low_flag; // see RULE17
         if (wr_sup) begin
            supply_low_irq_enable <= wd[watchdog_reset_flag_pkg::B_LOW_EN];
            supply_trigger_level <= wd[2:0];
         end
         supply_low_irq_req <= supply_low_irq_enable &
            next_supply_low_flag & ~supply_low_flag; // see RULE18
         supply_por_req <= below &
            (supply_trigger_level == watchdog_reset_flag_pkg::WATCHDOG_RESET_FLAG_LVL_POR_L ||
             supply_trigger_level == watchdog_reset_flag_pkg::WATCHDOG_RESET_FLAG_LVL_POR_H); // see RULE19
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   property p_flag_set;
      to_irq && !dev_reset |=> wd_timeout_irq_flag;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag not set"); // see RULE1

   property p_flag_vec;
      wd_vector_taken && !to_irq |=> !wd_timeout_irq_flag;
   endproperty
   a_flag_vec: assert property (p_flag_vec) else $error("vector left flag"); // see RULE2

   property p_flag_w0;
      wr_wdt && !wd[watchdog_reset_flag_pkg::B_TO_FLAG] && wd_timeout_irq_flag && !wd_vector_taken && !dev_reset
         |=> wd_timeout_irq_flag;
   endproperty
   a_flag_w0: assert property (p_flag_w0) else $error("zero write cleared flag"); // see RULE3

   property p_irq_gate;
      wd_irq_req |-> $past(irq_cond);
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("ungated request"); // see RULE4

   property p_fuse_rst;
      fuse_prog && cnt_bus.timeout && !wd_sys_reset |=> wd_sys_reset && !wd_timeout_irq_flag;
   endproperty
   a_fuse_rst: assert property (p_fuse_rst) else $error("fused time-out no reset"); // see RULE6

   property p_second_to;
      mode == watchdog_reset_flag_pkg::WATCHDOG_RESET_FLAG_IRQ_RST && wd_timeout_irq_flag && cnt_bus.timeout
         |=> wd_sys_reset;
   endproperty
   a_second_to: assert property (p_second_to) else $error("missed reset"); // see RULE8

   property p_rst_pulse;
      wd_sys_reset |-> $past(cnt_bus.timeout) ##1 !wd_sys_reset ##1 watchdog_reset_flag;
   endproperty
   a_rst_pulse: assert property (p_rst_pulse) else $error("bad reset pulse"); // see RULE16

   property p_wde_forced;
      watchdog_reset_flag && !dev_reset |=> wd_system_reset_enable;
   endproperty
   a_wde_forced: assert property (p_wde_forced) else $error("enable not forced"); // see RULE10

   property p_sup_irq;
      supply_low_irq_req |-> supply_low_flag && $past(supply_low_irq_enable);
   endproperty
   a_sup_irq: assert property (p_sup_irq) else $error("stray supply request"); // see RULE18

   c_irq_mode: cover property (mode == watchdog_reset_flag_pkg::WATCHDOG_RESET_FLAG_IRQ && to_irq);
   c_wd_reset: cover property (wd_sys_reset);
   c_unlock: cover property (win_open && wr_wdt);
   c_sup_irq: cover property (supply_low_irq_req);
endmodule

// ---- tb/watchdog_reset_flag_cpu_model.sv ----
// Core-side model that executes the watchdog vector when asked
module watchdog_reset_flag_cpu_model (
   input wire logic mclk,
   input wire logic rst,
   input wire logic irq_req,
   input wire logic service_en,
   input wire logic [7:0] lat,
   output logic vector_taken
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] wait_cnt;
   logic busy;
   // After a vector, wait for the request to fall so one request gives one vector
   always_ff @(posedge mclk) begin
      vector_taken <= 1'b0;
      if (rst) begin
         wait_cnt <= 8'h00;
         busy <= 1'b0;
      end else if (busy) begin
         busy <= irq_req;
      end else if (irq_req && service_en) begin
         wait_cnt <= wait_cnt + 8'h01;
         if (wait_cnt == lat) begin
            vector_taken <= 1'b1;
            busy <= 1'b1;
            wait_cnt <= 8'h00;
         end
      end
   end
endmodule

// ---- tb/watchdog_reset_flag_top_tb.sv ----
// Self-checking bench for the watchdog, reset flag and supply monitor block
module watchdog_reset_flag_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] A_WDT = {watchdog_reset_flag_pkg::IDX_WDT, 2'b00};
   localparam logic [7:0] A_RSF = {watchdog_reset_flag_pkg::IDX_RSF, 2'b00};
   localparam logic [7:0] A_SUP = {watchdog_reset_flag_pkg::IDX_SUP, 2'b00};
   localparam logic [7:0] A_UNL = {watchdog_reset_flag_pkg::IDX_UNLOCK, 2'b00};
   logic mclk, rst, wb_cyc, wb_stb, wb_we, wb_ack, osc, fuse, kick_q, vec, gie, pin, below;
   logic wd_irq_req, wd_sys_reset, sup_irq, sup_por, svc_en, rst_prev;
   logic [7:0] wb_adr, lat;
   logic [3:0] wb_sel, code;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic [1:0] osc_div;
   logic [7:0] exp_q[$];
   int err_total, comparisons, n_sysrst, n_sirq, n;

   watchdog_reset_flag_top DUT (.mclk(mclk), .rst(rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
      .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack(wb_ack), .wd_osc_clk(osc), .wd_always_on_fuse(fuse), .wd_restart(kick_q),
      .wd_vector_taken(vec), .global_irq_enable(gie), .pin_reset_req(pin),
      .supply_below_level(below), .wd_irq_req(wd_irq_req), .wd_sys_reset(wd_sys_reset),
      .supply_low_irq_req(sup_irq), .supply_por_req(sup_por));
   watchdog_reset_flag_cpu_model core (.mclk(mclk), .rst(rst), .irq_req(wd_irq_req), .service_en(svc_en),
      .lat(lat), .vector_taken(vec));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // Oscillator far faster than in silicon, one tick per four clocks, to keep runs short
   always @(posedge mclk) begin
      osc_div <= osc_div + 2'h1;
      osc <= osc_div[1];
   end

   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH at %0t: got 0x%h expected 0x%h", $time, got, exp);
      end
   endtask
   task automatic chk_sig(input logic got, input logic exp);
      chk_reg({31'h0, got}, {31'h0, exp});
   endtask
   task automatic chk_num(input int got, input int exp);
      chk_reg(got, exp);
   endtask
   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic timeout();
      err_total++;
      $display("MISMATCH at %0t: wait ran out, got 0x0 expected 0x1", $time);
      summarize();
   endtask

   // Read results are checked here, in the order the reads were issued
   always @(posedge mclk) begin
      rst_prev <= wd_sys_reset;
      if (wb_ack === 1'b1 && wb_we === 1'b0)
         chk_reg(wb_dat_o, {24'h00_0000, exp_q.pop_front()});
      if (wd_sys_reset === 1'b1) begin
         n_sysrst++;
         chk_sig(rst_prev, 1'b0);
      end
      if (sup_irq === 1'b1)
         n_sirq++;
   end

   task automatic bus(input logic [7:0] a, input logic we, input logic [7:0] d);
      int k;
      k = 0;
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_sel <= 4'hf;
      wb_dat_i <= {24'h00_0000, d};
      do begin
         @(posedge mclk);
         k++;
      end while (wb_ack !== 1'b1 && k < 50);
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we <= 1'b0;
      if (k >= 50)
         timeout();
      @(posedge mclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(a, 1'b1, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      bus(a, 1'b0, 8'h00);
   endtask
   task automatic kick();
      kick_q <= 1'b1;
      @(posedge mclk);
      kick_q <= 1'b0;
   endtask
   // Waits on the request (0), the vector (1) or the system reset (2)
   task automatic wait_for(input int w, input int lim);
      n = 0;
      while ((w == 0 ? wd_irq_req : w == 1 ? vec : wd_sys_reset) !== 1'b1) begin
         @(posedge mclk);
         n++;
         if (n > lim)
            timeout();
      end
   endtask
   task automatic por();
      rst <= 1'b1;
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      repeat (4) @(posedge mclk);
   endtask

   initial begin
      {wb_cyc, wb_stb, wb_we, kick_q, gie, pin, below, svc_en} = 8'h00;
      {wb_adr, wb_sel, lat, osc_div, osc} = 23'h0;
      wb_dat_i = 32'h0000_0000;
      fuse = 1'b1;
      rst = 1'b1;
      {err_total, comparisons, n_sysrst, n_sirq} = 128'h0;
      void'($urandom(34));
      repeat (4) @(posedge mclk);
      por();
      rd(A_WDT, 8'h00);
      rd(A_RSF, 8'h01);
      rd(A_SUP, 8'h00);
      rd(8'h00, 8'h00);
      rd(A_UNL, 8'h00);
      wr(A_RSF, 8'h00);
      rd(A_RSF, 8'h00);
      repeat (4) begin
         code = 4'($urandom % 10);
         wr(A_WDT, {2'b00, code[3], 2'b00, code[2:0]});
         rd(A_WDT, {2'b00, code[3], 2'b00, code[2:0]});
      end
      // Interrupt mode with code 0001: twice the base period
      wr(A_WDT, 8'h41);
      gie <= 1'b1;
      svc_en <= 1'b1;
      kick();
      wait_for(0, 17000);
      chk_num(int'(n > 16375 && n < 16405), 1);
      wait_for(1, 100);
      repeat (3) @(posedge mclk);
      rd(A_WDT, 8'h41);
      // Pending flag with global enable off gives no request
      gie <= 1'b0;
      wr(A_WDT, 8'h40);
      kick();
      repeat (8232) @(posedge mclk);
      chk_sig(wd_irq_req, 1'b0);
      rd(A_WDT, 8'hc0);
      wr(A_WDT, 8'h40);
      rd(A_WDT, 8'hc0);
      wr(A_WDT, 8'hc0);
      rd(A_WDT, 8'h40);
      // Fuse programmed: resets although both control bits are clear
      wr(A_WDT, 8'h00);
      fuse <= 1'b0;
      repeat (4) @(posedge mclk);
      rd(A_WDT, 8'h08);
      kick();
      wait_for(2, 8300);
      repeat (2) @(posedge mclk);
      rd(A_RSF, 8'h08);
      fuse <= 1'b1;
      // Combined mode, a slow core, re-armed twice, then left unserviced
      wr(A_RSF, 8'h00);
      wr(A_WDT, 8'h48);
      gie <= 1'b1;
      lat <= 8'h14;
      kick();
      wait_for(1, 8300);
      repeat (3) @(posedge mclk);
      rd(A_WDT, 8'h08);
      wr(A_WDT, 8'h48);
      wait_for(1, 8300);
      repeat (3) @(posedge mclk);
      rd(A_WDT, 8'h08);
      wr(A_WDT, 8'h48);
      svc_en <= 1'b0;
      wait_for(0, 8300);
      rd(A_WDT, 8'hc8);
      wait_for(2, 8300);
      repeat (2) @(posedge mclk);
      rd(A_RSF, 8'h08);
      rd(A_WDT, 8'h08);
      gie <= 1'b0;
      kick();
      wr(A_RSF, 8'h00);
      wr(A_WDT, 8'h00);
      rd(A_WDT, 8'h08);
      wr(A_UNL, watchdog_reset_flag_pkg::UNLOCK_SIG);
      wr(A_WDT, 8'h00);
      rd(A_WDT, 8'h00);
      repeat (8232) @(posedge mclk);
      rd(A_WDT, 8'h00);
      // Pin reset, then every supply level
      pin <= 1'b1;
      repeat (4) @(posedge mclk);
      pin <= 1'b0;
      repeat (4) @(posedge mclk);
      rd(A_RSF, 8'h02);
      for (int l = 0; l < 5; l++) begin
         wr(A_SUP, 8'h40 | 8'(l));
         below <= 1'b1;
         repeat (6) @(posedge mclk);
         chk_sig(sup_por, l == 1 || l == 2);
         rd(A_SUP, {l == 3 || l == 4, 7'h40 | 7'(l)});
         below <= 1'b0;
         repeat (6) @(posedge mclk);
         rd(A_SUP, 8'h40 | 8'(l));
      end
      below <= 1'b1;
      repeat (6) @(posedge mclk);
      wr(A_SUP, 8'h40);
      rd(A_SUP, 8'h40);
      below <= 1'b0;
      chk_num(n_sirq, 3);
      por();
      rd(A_RSF, 8'h01);
      chk_num(n_sysrst, 2);
      summarize();
   end
endmodule
